// *** rtl/pwdg_top.sv ***
module pwdg_top (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ls_osc_tick,
  input wire logic ls_osc_forced,
  input wire pwdg_pkg::pwdg_req_t bus_req,
  output logic [7:0] bus_rdata,
  output logic wdt_reset_pulse,
  output logic [7:0] reset_cause_register
);

  // Synchronised oscillator tick and option level
  logic tick_s1_ff, tick_s2_ff, tick_s3_ff;
  logic opt_s1_ff, opt_s2_ff;
  logic ls_tick;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tick_s1_ff <= 1'b0;
      tick_s2_ff <= 1'b0;
      tick_s3_ff <= 1'b0;
    end else begin
      tick_s1_ff <= ls_osc_tick;
      tick_s2_ff <= tick_s1_ff;
      tick_s3_ff <= tick_s2_ff;
    end
  end
  // Option level is not reset, so it is settled when reset lifts
  always_ff @(posedge clk) begin
    opt_s1_ff <= ls_osc_forced;
    opt_s2_ff <= opt_s1_ff;
  end
  assign ls_tick = tick_s2_ff & ~tick_s3_ff; // Rising edge of slow clock

  logic [7:0] mode_ff, nxt_mode;
  logic written_ff, nxt_written;
  logic [pwdg_pkg::CNT_W-1:0] cnt_ff, nxt_cnt;
  logic rst_ff, nxt_rst;
  logic cause_ff, nxt_cause;
  logic [7:0] rdata_ff, nxt_rdata;
  logic mode_wr, key_wr, stopped, use_sys, cnt_en, ovf, illegal;
  logic [4:0] exp_sel;
  logic [pwdg_pkg::CNT_W-1:0] limit;

  // Decode and counter control
  always_comb begin
    mode_wr = bus_req.wr && bus_req.addr == pwdg_pkg::MODE_ADDR;
    key_wr = bus_req.wr && bus_req.addr == pwdg_pkg::KEY_ADDR;
    stopped = mode_ff[pwdg_pkg::STOP_BIT];
    use_sys = ~mode_ff[pwdg_pkg::STOP_BIT] & mode_ff[pwdg_pkg::SRC_BIT];
    cnt_en = ~stopped & (use_sys | ls_tick);
    exp_sel = use_sys ? 5'(pwdg_pkg::SYS_EXP_BASE) : 5'(pwdg_pkg::LS_EXP_BASE);
    exp_sel = 5'(exp_sel + 5'(mode_ff[pwdg_pkg::IVL_MSB:0]));
    limit = pwdg_pkg::CNT_W'(({{(pwdg_pkg::CNT_W){1'b0}}, 1'b1} << exp_sel) - 1);
    ovf = cnt_en && cnt_ff == limit;
    illegal = ~stopped & ((mode_wr & written_ff)
      | (key_wr & bus_req.bit_op)
      | (key_wr & bus_req.wdata != pwdg_pkg::KEY_VALUE));
  end

  // Next-state logic
  always_comb begin
    nxt_mode = mode_ff;
    nxt_written = written_ff;
    nxt_cnt = cnt_ff;
    nxt_rst = ovf | illegal;
    nxt_cause = cause_ff | ovf | illegal;
    nxt_rdata = 8'h00;
    if (cnt_en) begin
      nxt_cnt = ovf ? '0 : pwdg_pkg::CNT_W'(cnt_ff + 1'b1);
    end
    if (mode_wr && !written_ff && !bus_req.bit_op) begin
      nxt_written = 1'b1;
      nxt_mode = {pwdg_pkg::MODE_RESET[7:5], bus_req.wdata[4:0]};
      if (opt_s2_ff) begin
        nxt_mode[pwdg_pkg::STOP_BIT:pwdg_pkg::SRC_BIT] = 2'b00;
      end
      nxt_cnt = '0;
    end
    if (key_wr && !bus_req.bit_op && bus_req.wdata == pwdg_pkg::KEY_VALUE) begin
      nxt_cnt = '0;
    end
    if (bus_req.rd) begin
      if (bus_req.addr == pwdg_pkg::MODE_ADDR) begin
        nxt_rdata = mode_ff;
      end else if (bus_req.addr == pwdg_pkg::KEY_ADDR) begin
        nxt_rdata = pwdg_pkg::KEY_RESET;
      end
    end
  end

  // State registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_ff <= pwdg_pkg::MODE_RESET;
      written_ff <= 1'b0;
      cnt_ff <= '0;
      rst_ff <= 1'b0;
      cause_ff <= 1'b0;
      rdata_ff <= pwdg_pkg::KEY_RESET;
    end else begin
      mode_ff <= nxt_mode;
      written_ff <= nxt_written;
      cnt_ff <= nxt_cnt;
      rst_ff <= nxt_rst;
      cause_ff <= nxt_cause;
      rdata_ff <= nxt_rdata;
    end
  end

  assign bus_rdata = rdata_ff;
  assign wdt_reset_pulse = rst_ff;
  always_comb begin
    reset_cause_register = 8'h00;
    reset_cause_register[pwdg_pkg::CAUSE_BIT] = cause_ff;
  end

  // Assertions
  property p_mode_reset;
    @(posedge clk) $fell(sys_rst) |-> mode_ff == pwdg_pkg::MODE_RESET;
  endproperty
  a_mode_reset: assert property (p_mode_reset) else $error("mode not 67 after reset");

  property p_second_write;
    @(posedge clk) disable iff (sys_rst)
      mode_wr && written_ff && !stopped |=> wdt_reset_pulse;
  endproperty
  a_second_write: assert property (p_second_write) else $error("second write no reset");

  property p_mode_once;
    @(posedge clk) disable iff (sys_rst) written_ff |=> $stable(mode_ff);
  endproperty
  a_mode_once: assert property (p_mode_once) else $error("mode changed twice");

  property p_stop_hold;
    @(posedge clk) disable iff (sys_rst) stopped |=> cnt_ff == $past(cnt_ff) || cnt_ff == 0;
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("stopped counter moved");

  property p_forced_src;
    @(posedge clk) disable iff (sys_rst)
      mode_wr && !written_ff && opt_s2_ff |=> mode_ff[4:3] == 2'b00;
  endproperty
  a_forced_src: assert property (p_forced_src) else $error("forced source overwritten");

  property p_stop_quiet;
    @(posedge clk) disable iff (sys_rst) stopped |=> !wdt_reset_pulse;
  endproperty
  a_stop_quiet: assert property (p_stop_quiet) else $error("reset while stopped");

  property p_key_clear;
    @(posedge clk) disable iff (sys_rst)
      key_wr && !bus_req.bit_op && bus_req.wdata == pwdg_pkg::KEY_VALUE && !mode_wr
      |=> cnt_ff == 0;
  endproperty
  a_key_clear: assert property (p_key_clear) else $error("key did not clear");

  property p_bad_key;
    @(posedge clk) disable iff (sys_rst)
      key_wr && bus_req.wdata != pwdg_pkg::KEY_VALUE && !stopped |=> wdt_reset_pulse;
  endproperty
  a_bad_key: assert property (p_bad_key) else $error("bad key no reset");

  property p_key_read;
    @(posedge clk) disable iff (sys_rst)
      bus_req.rd && bus_req.addr == pwdg_pkg::KEY_ADDR |=> bus_rdata == pwdg_pkg::KEY_RESET;
  endproperty
  a_key_read: assert property (p_key_read) else $error("key read not 9A");

  property p_pulse;
    @(posedge clk) disable iff (sys_rst) wdt_reset_pulse |-> reset_cause_register[4];
  endproperty
  a_pulse: assert property (p_pulse) else $error("cause flag missing");

  property p_ovf;
    @(posedge clk) disable iff (sys_rst) ovf |=> wdt_reset_pulse && cnt_ff == 0;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow no reset");

  // System clock source steps the count every cycle
  property p_sys_count;
    @(posedge clk) disable iff (sys_rst)
      use_sys && !ovf && !key_wr && !mode_wr |=> cnt_ff == $past(cnt_ff) + 1;
  endproperty
  a_sys_count: assert property (p_sys_count) else $error("system count did not step");

  // Slow source steps only on a synchronised edge
  property p_slow_step;
    @(posedge clk) disable iff (sys_rst)
      ls_tick && !use_sys && !stopped && !ovf && !key_wr && !mode_wr
      |=> cnt_ff == $past(cnt_ff) + 1;
  endproperty
  a_slow_step: assert property (p_slow_step) else $error("slow count did not step");

  property p_slow_hold;
    @(posedge clk) disable iff (sys_rst)
      !use_sys && !ls_tick && !key_wr && !mode_wr |=> $stable(cnt_ff);
  endproperty
  a_slow_hold: assert property (p_slow_hold) else $error("slow count moved");

  // Count never passes the selected interval
  property p_interval;
    @(posedge clk) disable iff (sys_rst)
      int'(cnt_ff) < (1 << ((use_sys ? pwdg_pkg::SYS_EXP_BASE : pwdg_pkg::LS_EXP_BASE)
        + int'(mode_ff[pwdg_pkg::IVL_MSB:0])));
  endproperty
  a_interval: assert property (p_interval) else $error("count beyond interval");

  // State seen at the first edge after reset release
  property p_start_long;
    @(posedge clk) $fell(sys_rst)
      |-> mode_ff[pwdg_pkg::IVL_MSB:0] == 3'h7 && !use_sys && !stopped;
  endproperty
  a_start_long: assert property (p_start_long) else $error("start not longest slow");

  property p_rdata_reset;
    @(posedge clk) $fell(sys_rst) |-> bus_rdata == pwdg_pkg::KEY_RESET;
  endproperty
  a_rdata_reset: assert property (p_rdata_reset) else $error("key value not 9A at reset");

  // Accepted mode write restarts the count
  property p_mode_clear;
    @(posedge clk) disable iff (sys_rst)
      mode_wr && !written_ff && !bus_req.bit_op |=> cnt_ff == 0 && written_ff;
  endproperty
  a_mode_clear: assert property (p_mode_clear) else $error("mode write kept count");

  // Ignored single-bit write to the mode register
  property p_bit_mode;
    @(posedge clk) disable iff (sys_rst)
      mode_wr && !written_ff && bus_req.bit_op |=> !written_ff && $stable(mode_ff);
  endproperty
  a_bit_mode: assert property (p_bit_mode) else $error("bit write took mode");

  // Illegal single-bit access to the key register
  property p_bit_key;
    @(posedge clk) disable iff (sys_rst)
      key_wr && bus_req.bit_op && !stopped |=> wdt_reset_pulse;
  endproperty
  a_bit_key: assert property (p_bit_key) else $error("bit key access no reset");

  // No pulse without a cause
  property p_quiet;
    @(posedge clk) disable iff (sys_rst)
      !ovf && !illegal |=> !wdt_reset_pulse;
  endproperty
  a_quiet: assert property (p_quiet) else $error("pulse without cause");

  // Cause flag holds until system reset
  property p_cause_sticky;
    @(posedge clk) disable iff (sys_rst)
      reset_cause_register[pwdg_pkg::CAUSE_BIT] |=> reset_cause_register[pwdg_pkg::CAUSE_BIT];
  endproperty
  a_cause_sticky: assert property (p_cause_sticky) else $error("cause flag dropped");

  // Read data follows the addressed register
  property p_mode_read;
    @(posedge clk) disable iff (sys_rst)
      bus_req.rd && bus_req.addr == pwdg_pkg::MODE_ADDR |=> bus_rdata == $past(mode_ff);
  endproperty
  a_mode_read: assert property (p_mode_read) else $error("mode read wrong");

  property p_idle_read;
    @(posedge clk) disable iff (sys_rst)
      !bus_req.rd |=> bus_rdata == 8'h00;
  endproperty
  a_idle_read: assert property (p_idle_read) else $error("read data without read");

  // Fixed upper mode bits
  property p_upper_bits;
    @(posedge clk) disable iff (sys_rst)
      mode_ff[7:5] == pwdg_pkg::MODE_RESET[7:5];
  endproperty
  a_upper_bits: assert property (p_upper_bits) else $error("upper mode bits wrong");

  c_mode_write: cover property (@(posedge clk) mode_wr && !written_ff);
  c_overflow: cover property (@(posedge clk) ovf);
  c_key_ok: cover property (@(posedge clk) key_wr && bus_req.wdata == pwdg_pkg::KEY_VALUE);
  c_stopped: cover property (@(posedge clk) stopped);
  c_bit_access: cover property (@(posedge clk) key_wr && bus_req.bit_op);

endmodule // pwdg_top

// *** rtl/pwdg_pkg.sv ***
package pwdg_pkg;
  // Register addresses on the internal register bus
  localparam logic [15:0] MODE_ADDR = 16'hff48;
  localparam logic [15:0] KEY_ADDR = 16'hff49;
  // Reset values and key
  localparam logic [7:0] MODE_RESET = 8'h67;
  localparam logic [7:0] KEY_RESET = 8'h9a;
  localparam logic [7:0] KEY_VALUE = 8'hac;
  // Mode field positions
  localparam int STOP_BIT = 4;
  localparam int SRC_BIT = 3;
  localparam int IVL_MSB = 2;
  // Interval exponent bases
  localparam int LS_EXP_BASE = 11;
  localparam int SYS_EXP_BASE = 13;
  localparam int CNT_W = 21;
  // Reset cause flag position
  localparam int CAUSE_BIT = 4;

  // Register bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic bit_op;
    logic [15:0] addr;
    logic [7:0] wdata;
  } pwdg_req_t;
endpackage

// *** test/pwdg_cpu_model.sv ***
module pwdg_cpu_model (
  input wire logic clk,
  output pwdg_pkg::pwdg_req_t bus_req,
  input wire logic [7:0] bus_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial bus_req = '0;
  // Byte store or load, held over one rising edge
  task automatic acc(input logic w, input logic b, input logic [15:0] a,
    input logic [7:0] d, output logic [7:0] q);
    @(negedge clk);
    bus_req = '{wr: w, rd: !w, bit_op: b, addr: a, wdata: d};
    @(negedge clk);
    q = bus_rdata;
    // Released address and data lines show the inverse of the last value; strobes drop to 0
    bus_req = '{wr: 1'b0, rd: 1'b0, bit_op: 1'b0, addr: ~a, wdata: ~d};
  endtask
endmodule // pwdg_cpu_model

// *** test/tb_pwdg_top.sv ***
module tb_pwdg_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] ma = pwdg_pkg::MODE_ADDR;
  localparam logic [15:0] ka = pwdg_pkg::KEY_ADDR;
  localparam logic [7:0] kv = pwdg_pkg::KEY_VALUE;
  logic clk = 0;
  logic sys_rst = 1;
  logic tick = 0;
  logic forced = 0;
  logic tick_en = 0;
  logic pulse;
  logic [7:0] rdata, cause, q;
  pwdg_pkg::pwdg_req_t req;
  int bad_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  int pcnt = 0;
  int n, p0;
  pwdg_top uut (.clk(clk), .sys_rst(sys_rst), .ls_osc_tick(tick),
    .ls_osc_forced(forced), .bus_req(req), .bus_rdata(rdata),
    .wdt_reset_pulse(pulse), .reset_cause_register(cause));
  pwdg_cpu_model cpu (.clk(clk), .bus_req(req), .bus_rdata(rdata));
  always #10 clk = ~clk;
  // Slow ticks, pulse count and run limit
  always @(negedge clk) begin
    cyc <= cyc + 1;
    if (tick_en && cyc % 4 == 0) tick <= ~tick;
    if (pulse === 1'b1) pcnt <= pcnt + 1;
    if (cyc == 70000) begin
      bad_count++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic b);
    cpu.acc(1'b1, b, a, d, q);
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
    cpu.acc(1'b0, 1'b0, a, 8'h00, q);
    chk(q, exp);
  endtask
  task automatic do_reset();
    sys_rst = 1;
    repeat (20) @(negedge clk);
    sys_rst = 0;
  endtask
  // Cycles until the next reset pulse
  task automatic wait_pulse(input int lim);
    n = 0;
    while (pulse !== 1'b1 && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask
  initial begin
    do_reset();
    rd_chk(ma, 8'h67);
    rd_chk(ka, 8'h9a);
    wr(ka, 8'h00, 1'b0);
    chk({7'h00, pulse}, 8'h01);
    chk(cause, 8'h10);
    @(negedge clk);
    chk({7'h00, pulse}, 8'h00);
    wr(ka, kv, 1'b1);
    chk({7'h00, pulse}, 8'h01);
    wr(ka, kv, 1'b0);
    chk({7'h00, pulse}, 8'h00);
    rd_chk(ka, 8'h9a);
    $display("test key done");
    do_reset();
    chk(cause, 8'h00);
    // No flash work runs here, so short intervals are safe
    wr(ma, 8'h68, 1'b0);
    rd_chk(ma, 8'h68);
    repeat (4000) @(negedge clk);
    wr(ka, kv, 1'b0);
    wait_pulse(9000);
    chk(8'(n > 8180 && n < 8200), 8'h01);
    wr(ma, 8'h6f, 1'b0);
    chk({7'h00, pulse}, 8'h01);
    rd_chk(ma, 8'h68);
    $display("test system clock done");
    // Forced slow source, then slow source by choice
    for (int i = 0; i < 2; i++) begin
      forced = (i == 0);
      do_reset();
      wr(ma, (i == 0) ? 8'h68 : 8'h60, 1'b0);
      wr(ka, kv, 1'b0);
      tick_en = 1;
      wait_pulse(17000);
      tick_en = 0;
      chk(8'(n > 16350 && n < 16420), 8'h01);
    end
    $display("test slow clock done");
    forced = 0;
    do_reset();
    p0 = pcnt;
    wr(ma, 8'h78, 1'b1);
    rd_chk(ma, 8'h67);
    wr(ma, 8'h78, 1'b0);
    wr(ma, 8'h68, 1'b0);
    wr(ka, 8'h00, 1'b0);
    wr(ka, kv, 1'b1);
    rd_chk(ma, 8'h78);
    tick_en = 1;
    repeat (9000) @(negedge clk);
    chk(8'(pcnt - p0), 8'h00);
    $display("test stopped done");
    stop_test();
  end
endmodule // tb_pwdg_top
